// ---- bench/testbench.sv ----
`timescale 1ns/10ps
module testbench;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, supplies_ok, over_temp, se;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] short_detect;
  dac_prot_pkg::chan_drive_s chan_out;
  int err_count, n_tests, cyc, pwr, alert, cen, ten, rel, ch;
  // 10 us host wait after power-up at 25 ns cycles
  localparam int power_up_wait = 400;
  dac_channel_protection_power DUT (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .supplies_ok(supplies_ok), .short_detect(short_detect),
    .over_temp(over_temp), .channel_output(chan_out));
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  // a run needs about 700 cycles, well under the 5000-cycle limit
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task stop_test;
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  // request held until pready seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d);
    if (a == dac_prot_pkg::off_power) begin
      if (cen == 0) alert &= ~(d & ~short_detect);
      pwr = d & 15;
    end
    if (a == dac_prot_pkg::off_control) begin
      cen = d[0];
      ten = d[1];
    end
    if (a == dac_prot_pkg::off_dac_written) rel = 1;
  endtask
  // model settles after the sense synchronisers
  task check_all;
    repeat (6) @(posedge clk);
    if (cen) alert = short_detect;
    else begin
      alert |= short_detect;
      pwr &= ~short_detect;
    end
    if (ten && over_temp) pwr = 0;
    apb(0, dac_prot_pkg::off_power, 0);
    chk("power", pwr | (alert << 7) | ((ten && over_temp) ? 32 : 0), rd);
    chk("slverr_ok", 0, se);
    apb(0, dac_prot_pkg::off_faults, 0);
    chk("faults", short_detect | (over_temp ? 32 : 0), rd);
    apb(0, dac_prot_pkg::off_dac_written, 0);
    chk("dac", (supplies_ok ? 8 : 0) | (rel ? 4 : 0), rd);
    chk("clamp", (rel && supplies_ok) ? (~pwr & 15) : 15, chan_out.clamp);
    chk("amp", (rel && supplies_ok) ? pwr : 0, chan_out.amp_connect);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata, supplies_ok, short_detect, over_temp} = 0;
    cen = 1;
    void'($urandom(94));
    repeat (16) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    check_all;
    apb(0, dac_prot_pkg::off_control, 0);
    chk("control", 1, rd);
    wr(dac_prot_pkg::off_power, 32'hf);
    check_all;
    repeat (power_up_wait) @(posedge clk);
    supplies_ok <= 1;
    wr(dac_prot_pkg::off_dac_written, $urandom);
    check_all;
    wr(dac_prot_pkg::off_power, 32'h7af);
    check_all;
    for (int m = 1; m >= 0; m--) begin
      wr(dac_prot_pkg::off_control, m);
      ch = $urandom % 4;
      short_detect <= 4'h1 << ch;
      check_all;
      short_detect <= 0;
      check_all;
      wr(dac_prot_pkg::off_power, 32'hf);
      check_all;
    end
    over_temp <= 1;
    check_all;
    wr(dac_prot_pkg::off_control, 3);
    check_all;
    wr(dac_prot_pkg::off_power, 32'hf);
    check_all;
    over_temp <= 0;
    // let the synchronised trip drop before re-arming, or the write loses
    check_all;
    wr(dac_prot_pkg::off_power, 32'hf);
    check_all;
    apb(1, 8'h10, $urandom);
    chk("slverr", 1, se);
    apb(0, 8'h10, 0);
    chk("unmapped", 0, rd);
    stop_test();
  end
endmodule // testbench

// ---- rtl/dac_channel_protection_power.sv ----
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/10ps
// What this block does
// - outputs clamped until supplies stable and word written
// - four independent power-down states, all down at reset
// - powered-down channel clamped, amplifier disconnected
// - clamp-enable bit picks overcurrent response
// - clamp mode: alert follows short, self clears
// - auto mode: short powers down, sets alert
// - thermal shutdown off at reset, enable bit
// - thermal event sets thermal alert bit only while shutdown is enabled
// - thermal shutdown powers down all channels
// - power register reached with select 010
module dac_channel_protection_power (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog sense pins, asynchronous
  input wire logic supplies_ok,
  input wire logic [3:0] short_detect,
  input wire logic over_temp,
  // analog switch controls
  output dac_prot_pkg::chan_drive_s channel_output
);
  ////////////////////////////////////////////////////////////////
  logic [1:0] sup_s;
  logic [3:0] sh_s0, sh_s1;
  logic [1:0] ot_s;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sup_s <= 2'h0;
      sh_s0 <= 4'h0;
      sh_s1 <= 4'h0;
      ot_s <= 2'h0;
    end else begin
      sup_s <= {sup_s[0], supplies_ok};
      sh_s0 <= short_detect;
      sh_s1 <= sh_s0;
      ot_s <= {ot_s[0], over_temp};
    end
  end
  wire supply_ok = sup_s[1];
  wire [3:0] shorted = sh_s1;
  wire hot = ot_s[1];
  ////////////////////////////////////////////////////////////////
  // apb decode, zero wait states
  logic [3:0] channel_power_up;
  logic [3:0] overcurrent_alert;
  logic thermal_alert;
  logic clamp_en;
  logic thermal_en;
  logic word_written;
  wire wr = psel && penable && pwrite;
  wire wr_power = wr && paddr == dac_prot_pkg::off_power;
  wire wr_ctrl = wr && paddr == dac_prot_pkg::off_control;
  wire wr_dac = wr && paddr == dac_prot_pkg::off_dac_written;
  wire mapped = paddr == dac_prot_pkg::off_power || paddr == dac_prot_pkg::off_control ||
                paddr == dac_prot_pkg::off_dac_written || paddr == dac_prot_pkg::off_faults;
  // power register: overcurrent bits, thermal bit, power-up bits; the rest read zero
  wire [31:0] power_word = {21'h0, overcurrent_alert, 1'b0, thermal_alert, 1'b0,
                            channel_power_up};
  wire [31:0] ctrl_word = {30'h0, thermal_en, clamp_en};
  wire [31:0] dac_word = {28'h0, supply_ok, word_written, dac_prot_pkg::sel_dac[1:0]};
  wire [31:0] fault_word = {26'h0, hot, 1'b0, shorted};
  wire [31:0] rd_mux = paddr == dac_prot_pkg::off_power ? power_word :
                       paddr == dac_prot_pkg::off_control ? ctrl_word :
                       paddr == dac_prot_pkg::off_dac_written ? dac_word :
                       paddr == dac_prot_pkg::off_faults ? fault_word : 32'h0;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) prdata <= 32'h0;
    else if (psel && !penable && !pwrite) prdata <= rd_mux;
  end
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      clamp_en <= dac_prot_pkg::clamp_en_reset;
      thermal_en <= dac_prot_pkg::thermal_en_reset;
    end else if (wr_ctrl) begin
      clamp_en <= pwdata[dac_prot_pkg::pos_clamp_en];
      thermal_en <= pwdata[dac_prot_pkg::pos_thermal_en];
    end
  end
  // a word written before supplies settle still counts once they do
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) word_written <= 1'b0;
    else if (wr_dac) word_written <= 1'b1;
  end
  wire released = supply_ok && word_written;
  ////////////////////////////////////////////////////////////////
  wire thermal_trip = thermal_en && hot;
  wire [3:0] auto_off = clamp_en ? 4'h0 : shorted;
  wire [3:0] host_power_up = pwdata[dac_prot_pkg::pos_power_up +: 4];
  // fault clears win over host power-up writes so a short cannot be re-armed
  wire [3:0] next_power_up = thermal_trip ? 4'h0 :
    ((wr_power ? host_power_up : channel_power_up) & ~auto_off);
  // auto mode: a power-up write clears the alert only where the short is gone
  wire [3:0] alert_clear = wr_power ? (host_power_up & ~shorted) : 4'h0;
  // alert follows the short in clamp mode, latched in auto mode
  wire [3:0] next_alert = clamp_en ? shorted :
    ((overcurrent_alert & ~alert_clear) | shorted);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      channel_power_up <= dac_prot_pkg::power_up_reset;
      overcurrent_alert <= 4'h0;
      thermal_alert <= 1'b0;
    end else begin
      channel_power_up <= next_power_up;
      overcurrent_alert <= next_alert;
      thermal_alert <= thermal_trip ? 1'b1 : (thermal_alert && hot && thermal_en);
    end
  end
  ////////////////////////////////////////////////////////////////
  wire [3:0] live = channel_power_up & {4{released}};
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      channel_output.clamp <= 4'hf;
      channel_output.amp_connect <= 4'h0;
    end else begin
      channel_output.clamp <= ~live;
      channel_output.amp_connect <= live;
    end
  end
  ////////////////////////////////////////////////////////////////
  property p_clamp_when_down;
    @(posedge clk) disable iff (!nrst)
      !channel_power_up[0] |=> channel_output.clamp[0] && !channel_output.amp_connect[0];
  endproperty
  a_clamp_when_down: assert property (p_clamp_when_down) else $error("ch0 not clamped");
  property p_hold_until_word;
    @(posedge clk) disable iff (!nrst)
      !released |=> channel_output.amp_connect == 4'h0;
  endproperty
  a_hold_until_word: assert property (p_hold_until_word) else $error("amp early");
  property p_auto_off;
    @(posedge clk) disable iff (!nrst)
      (!clamp_en && shorted[1]) |=> !channel_power_up[1] && overcurrent_alert[1];
  endproperty
  a_auto_off: assert property (p_auto_off) else $error("auto power-down missing");
  property p_clamp_keeps;
    @(posedge clk) disable iff (!nrst)
      (clamp_en && shorted[2] && channel_power_up[2] && !wr_power && !thermal_trip)
        |=> channel_power_up[2] && overcurrent_alert[2];
  endproperty
  a_clamp_keeps: assert property (p_clamp_keeps) else $error("clamp mode wrong");
  property p_clamp_clear;
    @(posedge clk) disable iff (!nrst)
      (clamp_en && !shorted[3]) |=> !overcurrent_alert[3];
  endproperty
  a_clamp_clear: assert property (p_clamp_clear) else $error("alert stuck");
  property p_thermal;
    @(posedge clk) disable iff (!nrst)
      thermal_trip |=> channel_power_up == 4'h0 && thermal_alert;
  endproperty
  a_thermal: assert property (p_thermal) else $error("thermal shutdown missing");
  property p_thermal_off;
    @(posedge clk) disable iff (!nrst)
      (!thermal_en && !thermal_alert) |=> !thermal_alert;
  endproperty
  a_thermal_off: assert property (p_thermal_off) else $error("thermal while off");
  property p_ro_thermal;
    @(posedge clk) disable iff (!nrst)
      (wr_power && !thermal_trip && !thermal_alert) |=> !thermal_alert;
  endproperty
  a_ro_thermal: assert property (p_ro_thermal) else $error("host set alert");
  property p_write_power;
    @(posedge clk) disable iff (!nrst)
      (wr_power && !thermal_trip && clamp_en) |=> channel_power_up == $past(host_power_up);
  endproperty
  a_write_power: assert property (p_write_power) else $error("power write lost");
  property p_auto_write;
    @(posedge clk) disable iff (!nrst)
      (wr_power && !thermal_trip && !clamp_en)
        |=> channel_power_up == ($past(host_power_up) & ~$past(shorted));
  endproperty
  a_auto_write: assert property (p_auto_write) else $error("short re-armed");
  property p_alert_sticky;
    @(posedge clk) disable iff (!nrst)
      (!clamp_en && overcurrent_alert[0] && !(wr_power && host_power_up[0]))
        |=> overcurrent_alert[0];
  endproperty
  a_alert_sticky: assert property (p_alert_sticky) else $error("alert lost");
  property p_alert_ro;
    @(posedge clk) disable iff (!nrst)
      (wr_power && clamp_en && !shorted[1]) |=> !overcurrent_alert[1];
  endproperty
  a_alert_ro: assert property (p_alert_ro) else $error("host set overcurrent");
  property p_release;
    @(posedge clk) disable iff (!nrst)
      (released && channel_power_up[1])
        |=> channel_output.amp_connect[1] && !channel_output.clamp[1];
  endproperty
  a_release: assert property (p_release) else $error("channel not released");
  property p_stays_down;
    @(posedge clk) disable iff (!nrst)
      (!channel_power_up[0] && !wr_power) |=> !channel_power_up[0];
  endproperty
  a_stays_down: assert property (p_stays_down) else $error("channel woke alone");
  property p_mapped_ok;
    @(posedge clk) disable iff (!nrst)
      (psel && penable && paddr == dac_prot_pkg::off_power) |-> !pslverr;
  endproperty
  a_mapped_ok: assert property (p_mapped_ok) else $error("error on power register");
  property p_thermal_dis;
    @(posedge clk) disable iff (!nrst)
      !thermal_en |=> !thermal_alert;
  endproperty
  a_thermal_dis: assert property (p_thermal_dis) else $error("alert with trip off");
  c_live: cover property (@(posedge clk) disable iff (!nrst) channel_output.amp_connect[0]);
  c_auto: cover property (@(posedge clk) disable iff (!nrst) !clamp_en && shorted[0]);
  c_therm: cover property (@(posedge clk) disable iff (!nrst) thermal_trip);
  // clamp mode keeps a shorted channel driving
  c_clamp_short: cover property (@(posedge clk) disable iff (!nrst)
    clamp_en && (shorted & channel_output.amp_connect) != 4'h0);
  c_recover: cover property (@(posedge clk) disable iff (!nrst)
    !clamp_en && wr_power && overcurrent_alert != 4'h0);
endmodule // dac_channel_protection_power

// ---- rtl/dac_prot_pkg.sv ----
package dac_prot_pkg;
  localparam int n_chan = 4;
  // register byte offsets on apb
  localparam logic [7:0] off_power = 8'h08;
  localparam logic [7:0] off_control = 8'h04;
  localparam logic [7:0] off_dac_written = 8'h00;
  localparam logic [7:0] off_faults = 8'h0c;
  // power control word layout
  localparam int pos_power_up = 0;
  localparam int pos_thermal = 5;
  localparam int pos_overcurrent = 7;
  // control word layout
  localparam int pos_clamp_en = 0;
  localparam int pos_thermal_en = 1;
  // select code that addresses the power control register
  localparam logic [2:0] sel_power = 3'h2;
  localparam logic [2:0] sel_dac = 3'h0;
  localparam logic [3:0] power_up_reset = 4'h0;
  localparam logic clamp_en_reset = 1'b1;
  localparam logic thermal_en_reset = 1'b0;
  typedef struct packed {
    logic [3:0] clamp;
    logic [3:0] amp_connect;
  } chan_drive_s;
endpackage
